// >>> include/mcuod_pkg.sv
// opcode classes, operand forms and cycle counts of the controller decoder
package mcuod_pkg;

  localparam int ADDR_W = 12;
  localparam int CYC_W  = 4;

  localparam logic [CYC_W-1:0] CYC_HALT     = 4'h7;
  localparam logic [CYC_W-1:0] CYC_NOP      = 4'h4;
  localparam logic [CYC_W-1:0] CYC_ALU_IMM  = 4'h4;
  localparam logic [CYC_W-1:0] CYC_ALU_DIR  = 4'h6;
  localparam logic [CYC_W-1:0] CYC_ALU_IDX  = 4'h7;
  localparam logic [CYC_W-1:0] CYC_CMP_IMM  = 4'h5;
  localparam logic [CYC_W-1:0] CYC_CMP_DIR  = 4'h7;
  localparam logic [CYC_W-1:0] CYC_CMP_IDX  = 4'h8;
  localparam logic [CYC_W-1:0] CYC_LD_IMM   = 4'h4;
  localparam logic [CYC_W-1:0] CYC_LD_DIR   = 4'h5;
  localparam logic [CYC_W-1:0] CYC_LD_IDX   = 4'h6;
  localparam logic [CYC_W-1:0] CYC_IRET     = 4'hd;
  localparam logic [CYC_W-1:0] CYC_PAGE     = 4'h4;
  localparam logic [CYC_W-1:0] CYC_REG_OP   = 4'h4;
  localparam logic [CYC_W-1:0] CYC_RMW_DIR  = 4'h7;
  localparam logic [CYC_W-1:0] CYC_RMW_IDX  = 4'h8;
  localparam logic [CYC_W-1:0] CYC_PORT     = 4'h5;
  localparam logic [CYC_W-1:0] CYC_PORT_IDX = 4'h6;
  localparam logic [CYC_W-1:0] CYC_POP      = 4'h4;
  localparam logic [CYC_W-1:0] CYC_PUSH     = 4'h5;
  localparam logic [CYC_W-1:0] CYC_SWAP     = 4'h5;
  localparam logic [CYC_W-1:0] CYC_ST_DIR   = 4'h5;
  localparam logic [CYC_W-1:0] CYC_ST_IDX   = 4'h6;
  localparam logic [CYC_W-1:0] CYC_RET      = 4'h8;
  localparam logic [CYC_W-1:0] CYC_JMP      = 4'h5;
  localparam logic [CYC_W-1:0] CYC_CALL     = 4'ha;
  localparam logic [CYC_W-1:0] CYC_JUMP_ACCUMULATOR_RELATIVE     = 4'h7;
  localparam logic [CYC_W-1:0] CYC_TABLE    = 4'he;

  // cycle index of the opcode cycle, the operand cycle and the cycle in which the decoded instruction is issued
  localparam logic [CYC_W-1:0] CNT_OPC   = 4'h1;
  localparam logic [CYC_W-1:0] CNT_OPR   = 4'h2;
  localparam logic [CYC_W-1:0] CNT_ISSUE = 4'h3;

  typedef enum logic [5:0] {
    OP_ILLEGAL, OP_HALT, OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW,
    OP_OR, OP_AND, OP_XOR, OP_CMP, OP_LOAD_ACC, OP_LOAD_X,
    OP_INTERRUPT_RETURN_WITH_OUTPUT, OP_PAGE_EXTEND_PREFIX, OP_INC, OP_DEC,
    OP_PORT_READ, OP_PORT_WRITE, OP_PORT_WRITE_INDEXED, OP_POP, OP_PUSH,
    OP_SWAP_X, OP_SWAP_DSP, OP_STORE, OP_OR_MEM, OP_AND_MEM, OP_XOR_MEM,
    OP_COMPLEMENT_ACCUMULATOR, OP_SHIFT_LEFT_ARITH, OP_SHIFT_RIGHT_ARITH,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_RETURN, OP_JUMP, OP_CALL,
    OP_JUMP_IF_ZERO, OP_JUMP_IF_NOT_ZERO, OP_JUMP_IF_CARRY, OP_JUMP_IF_NO_CARRY,
    OP_JUMP_ACCUMULATOR_RELATIVE, OP_TABLE_READ
  } mcuod_op_e;

  typedef enum logic [3:0] {
    MODE_NONE, MODE_IMM, MODE_DIRECT, MODE_INDEXED, MODE_ACC, MODE_XREG,
    MODE_PORT, MODE_ADDR
  } mcuod_mode_e;

  typedef struct packed {
    mcuod_op_e          op;
    mcuod_mode_e        mode;
    logic [CYC_W-1:0]   cyc;
    logic               has_opr;
  } mcuod_dec_s;

endpackage

// >>> src/mcuod_decode.sv
// opcode decoder, operand fetch and cycle timer of the controller core
//
// Contract
// - 00 is stop, 7 cycles; 20 is no-operation, 4 cycles.
// - add: 01 immediate 4, 02 direct 6, 03 indexed 7 cycles.
// - add-with-carry: 04 immediate 4, 05 direct 6, 06 indexed 7.
// - subtract: 07 immediate 4, 08 direct 6, 09 indexed 7.
// - subtract-with-borrow: 0A immediate 4, 0B direct 6, 0C indexed 7.
// - or: 0D immediate 4, 0E direct 6, 0F indexed 7.
// - and: 10 immediate 4, 11 direct 6, 12 indexed 7.
// - exclusive-or: 13 immediate 4, 14 direct 6, 15 indexed 7.
// - compare: 16 immediate 5, 17 direct 7, 18 indexed 8.
// - load accumulator: 19 immediate 4, 1A direct 5, 1B indexed 6.
// - load index register: 1C immediate 4, 1D direct 5.
// - 1E interrupt return with port output 13; 1F page prefix 4.
// - increments 21-24, decrements 25-28; register 4, direct 7, indexed 8.
// - 29 port read, 2A port write, 5 cycles; 39 indexed write 6.
// - pops 2B/2C take 4 cycles; pushes 2D/2E take 5.
// - 2F swaps accumulator/index, 30 accumulator/stack pointer, 5 cycles.
// - store accumulator: 31 direct 5, 32 indexed 6 cycles.
// - memory or 33/34, and 35/36, xor 37/38; direct 7, indexed 8.
// - 3A-3E accumulator one-operand ops take 4; 3F return takes 8.
// - 8x jump 5, 9x call 10, Ax jump-if-zero 5, Bx jump-if-not-zero 5.
// - Cx/Dx carry jumps 5, Ex accumulator jump 7, Fx table read 14.
`timescale 1ns/10ps

module mcuod_decode (
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic [7:0]                    fetch_data,
  input  wire logic                          zero_flag,
  input  wire logic                          carry_flag,
  input  wire logic                          redirect_valid,
  input  wire logic [mcuod_pkg::ADDR_W-1:0]  redirect_pc,
  output logic                               fetch_en,
  output logic                               fetch_opcode,
  output logic [mcuod_pkg::ADDR_W-1:0]       fetch_addr,
  output logic                               op_issue,
  output mcuod_pkg::mcuod_op_e               op_class,
  output mcuod_pkg::mcuod_mode_e             op_mode,
  output logic [7:0]                         op_operand,
  output logic [mcuod_pkg::ADDR_W-1:0]       op_target,
  output logic [mcuod_pkg::CYC_W-1:0]        op_cycles,
  output logic                               op_illegal,
  output logic                               op_last,
  output logic                               halted
);
  import mcuod_pkg::*;

  typedef enum logic [2:0] {S_FETCH, S_OPC, S_OPR, S_EXEC, S_HALT} mcuod_st_e;

  typedef struct packed {
    mcuod_st_e          st;
    logic [CYC_W-1:0]   cnt;
    logic [ADDR_W-1:0]  pc;
    logic [7:0]         opc;
    logic [7:0]         opr;
    mcuod_dec_s         dec;
    logic               issue;
    logic               redir;
    logic [ADDR_W-1:0]  redir_pc;
  } mcuod_state_s;

  // ****************************************
  // opcode table
  // ****************************************
  function automatic mcuod_dec_s decode(input logic [7:0] b);
    mcuod_dec_s d;
    d = '{op: OP_ILLEGAL, mode: MODE_NONE, cyc: CYC_NOP, has_opr: 1'b0};
    if (b[7]) begin
      d.mode = MODE_ADDR;
      d.cyc  = CYC_JMP;
      unique case (b[6:4])
        3'h0: d.op = OP_JUMP;
        3'h1: begin
          d.op  = OP_CALL;
          d.cyc = CYC_CALL;
        end
        3'h2: d.op = OP_JUMP_IF_ZERO;
        3'h3: d.op = OP_JUMP_IF_NOT_ZERO;
        3'h4: d.op = OP_JUMP_IF_CARRY;
        3'h5: d.op = OP_JUMP_IF_NO_CARRY;
        3'h6: begin
          d.op  = OP_JUMP_ACCUMULATOR_RELATIVE;
          d.cyc = CYC_JUMP_ACCUMULATOR_RELATIVE;
        end
        3'h7: begin
          d.op  = OP_TABLE_READ;
          d.cyc = CYC_TABLE;
        end
      endcase
    end else if (!b[6]) begin
      unique case (b)
        8'h00: d.op = OP_HALT;
        8'h20: d.op = OP_NOP;
        8'h01, 8'h02, 8'h03: d.op = OP_ADD;
        8'h04, 8'h05, 8'h06: d.op = OP_ADD_CARRY;
        8'h07, 8'h08, 8'h09: d.op = OP_SUB;
        8'h0a, 8'h0b, 8'h0c: d.op = OP_SUBTRACT_WITH_BORROW;
        8'h0d, 8'h0e, 8'h0f: d.op = OP_OR;
        8'h10, 8'h11, 8'h12: d.op = OP_AND;
        8'h13, 8'h14, 8'h15: d.op = OP_XOR;
        8'h16, 8'h17, 8'h18: d.op = OP_CMP;
        8'h19, 8'h1a, 8'h1b: d.op = OP_LOAD_ACC;
        8'h1c, 8'h1d:        d.op = OP_LOAD_X;
        8'h1e: d.op = OP_INTERRUPT_RETURN_WITH_OUTPUT;
        8'h1f: d.op = OP_PAGE_EXTEND_PREFIX;
        8'h21, 8'h22, 8'h23, 8'h24: d.op = OP_INC;
        8'h25, 8'h26, 8'h27, 8'h28: d.op = OP_DEC;
        8'h29: d.op = OP_PORT_READ;
        8'h2a: d.op = OP_PORT_WRITE;
        8'h39: d.op = OP_PORT_WRITE_INDEXED;
        8'h2b, 8'h2c: d.op = OP_POP;
        8'h2d, 8'h2e: d.op = OP_PUSH;
        8'h2f: d.op = OP_SWAP_X;
        8'h30: d.op = OP_SWAP_DSP;
        8'h31, 8'h32: d.op = OP_STORE;
        8'h33, 8'h34: d.op = OP_OR_MEM;
        8'h35, 8'h36: d.op = OP_AND_MEM;
        8'h37, 8'h38: d.op = OP_XOR_MEM;
        8'h3a: d.op = OP_COMPLEMENT_ACCUMULATOR;
        8'h3b: d.op = OP_SHIFT_LEFT_ARITH;
        8'h3c: d.op = OP_SHIFT_RIGHT_ARITH;
        8'h3d: d.op = OP_ROTATE_LEFT_CARRY;
        8'h3e: d.op = OP_ROTATE_RIGHT_CARRY;
        8'h3f: d.op = OP_RETURN;
        default: ;
      endcase
      // operand form and cycle count
      unique case (b)
        8'h00: d.cyc = CYC_HALT;
        8'h01, 8'h04, 8'h07, 8'h0a, 8'h0d, 8'h10, 8'h13: begin
          d.mode = MODE_IMM;
          d.cyc  = CYC_ALU_IMM;
        end
        8'h02, 8'h05, 8'h08, 8'h0b, 8'h0e, 8'h11, 8'h14: begin
          d.mode = MODE_DIRECT;
          d.cyc  = CYC_ALU_DIR;
        end
        8'h03, 8'h06, 8'h09, 8'h0c, 8'h0f, 8'h12, 8'h15: begin
          d.mode = MODE_INDEXED;
          d.cyc  = CYC_ALU_IDX;
        end
        8'h16: begin d.mode = MODE_IMM;     d.cyc = CYC_CMP_IMM; end
        8'h17: begin d.mode = MODE_DIRECT;  d.cyc = CYC_CMP_DIR; end
        8'h18: begin d.mode = MODE_INDEXED; d.cyc = CYC_CMP_IDX; end
        8'h19, 8'h1c: begin d.mode = MODE_IMM;    d.cyc = CYC_LD_IMM; end
        8'h1a, 8'h1d: begin d.mode = MODE_DIRECT; d.cyc = CYC_LD_DIR; end
        8'h1b: begin d.mode = MODE_INDEXED; d.cyc = CYC_LD_IDX; end
        8'h1e: begin d.mode = MODE_PORT; d.cyc = CYC_IRET; end
        8'h1f: d.cyc = CYC_PAGE;
        8'h21, 8'h25: begin d.mode = MODE_ACC;  d.cyc = CYC_REG_OP; end
        8'h22, 8'h26: begin d.mode = MODE_XREG; d.cyc = CYC_REG_OP; end
        8'h23, 8'h27, 8'h33, 8'h35, 8'h37: begin
          d.mode = MODE_DIRECT;
          d.cyc  = CYC_RMW_DIR;
        end
        8'h24, 8'h28, 8'h34, 8'h36, 8'h38: begin
          d.mode = MODE_INDEXED;
          d.cyc  = CYC_RMW_IDX;
        end
        8'h29, 8'h2a: begin d.mode = MODE_PORT; d.cyc = CYC_PORT; end
        8'h39: begin d.mode = MODE_INDEXED; d.cyc = CYC_PORT_IDX; end
        8'h2b, 8'h2d: begin
          d.mode = MODE_ACC;
          d.cyc  = b[1] ? CYC_POP : CYC_PUSH;
        end
        8'h2c, 8'h2e: begin
          d.mode = MODE_XREG;
          d.cyc  = b[1] ? CYC_PUSH : CYC_POP;
        end
        8'h2f, 8'h30: d.cyc = CYC_SWAP;
        8'h31: begin d.mode = MODE_DIRECT;  d.cyc = CYC_ST_DIR; end
        8'h32: begin d.mode = MODE_INDEXED; d.cyc = CYC_ST_IDX; end
        8'h3f: d.cyc = CYC_RET;
        default: ;
      endcase
    end
    d.has_opr = d.mode inside {MODE_IMM, MODE_DIRECT, MODE_INDEXED, MODE_PORT,
                               MODE_ADDR};
    return d;
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // sequencer
  // ****************************************
  mcuod_state_s      s_q;
  mcuod_state_s      s_d;
  mcuod_dec_s        dec_now;
  logic [ADDR_W-1:0] target;
  logic              taken;
  logic              last;

  assign dec_now = decode(fetch_data);
  assign target  = {s_q.opc[3:0], s_q.opr};
  assign last    = (s_q.st == S_EXEC) && (s_q.cnt == s_q.dec.cyc - 4'h1);

  always_comb begin
    unique case (s_q.dec.op)
      OP_JUMP, OP_CALL:    taken = 1'b1;
      OP_JUMP_IF_ZERO:     taken = zero_flag;
      OP_JUMP_IF_NOT_ZERO: taken = !zero_flag;
      OP_JUMP_IF_CARRY:    taken = carry_flag;
      OP_JUMP_IF_NO_CARRY: taken = !carry_flag;
      default:             taken = 1'b0;
    endcase
  end

  always_comb begin
    s_d       = s_q;
    s_d.issue = 1'b0;
    // datapath may redirect the next fetch any time from the operand cycle on
    if (redirect_valid && (s_q.st inside {S_OPR, S_EXEC})) begin
      s_d.redir    = 1'b1;
      s_d.redir_pc = redirect_pc;
    end
    unique case (s_q.st)
      S_FETCH: begin
        s_d.st    = S_OPC;
        s_d.cnt   = CNT_OPC;
        s_d.pc    = s_q.pc + 12'h001;
        s_d.redir = 1'b0;
      end
      S_OPC: begin
        s_d.st  = S_OPR;
        s_d.cnt = CNT_OPR;
        s_d.opc = fetch_data;
        s_d.dec = dec_now;
        if (dec_now.has_opr) begin
          s_d.pc = s_q.pc + 12'h001;
        end
      end
      S_OPR: begin
        s_d.st    = S_EXEC;
        s_d.cnt   = CNT_ISSUE;
        s_d.opr   = s_q.dec.has_opr ? fetch_data : 8'h00;
        s_d.issue = 1'b1;
      end
      S_EXEC: begin
        if (last) begin
          s_d.cnt = '0;
          s_d.st  = (s_q.dec.op == OP_HALT) ? S_HALT : S_FETCH;
          if (s_d.redir) begin
            s_d.pc = s_d.redir_pc;
          end else if (taken) begin
            s_d.pc = target;
          end
        end else begin
          s_d.cnt = s_q.cnt + 4'h1;
        end
      end
      S_HALT: ;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_opcode = (s_q.st == S_FETCH);
  assign fetch_en     = fetch_opcode || ((s_q.st == S_OPC) && dec_now.has_opr);
  assign fetch_addr   = s_q.pc;
  assign op_issue     = s_q.issue;
  assign op_class     = s_q.dec.op;
  assign op_mode      = s_q.dec.mode;
  assign op_operand   = s_q.opr;
  assign op_target    = target;
  assign op_cycles    = s_q.dec.cyc;
  assign op_illegal   = s_q.issue && (s_q.dec.op == OP_ILLEGAL);
  assign op_last      = last;
  assign halted       = (s_q.st == S_HALT);

  // ****************************************
  // checks
  // ****************************************
  logic [CYC_W-1:0] gap_q;
  logic [CYC_W-1:0] prev_cyc_q;
  logic             seen_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_q      <= '0;
      prev_cyc_q <= '0;
      seen_q     <= 1'b0;
    end else begin
      gap_q <= fetch_opcode ? 4'h1 : gap_q + 4'h1;
      if (op_issue) begin
        prev_cyc_q <= op_cycles;
        seen_q     <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_NOP_LEN: assert property (
    fetch_opcode ##1 (fetch_data == 8'h20) |=> !fetch_opcode [*2] ##1 fetch_opcode)
    else $error("no-operation did not take 4 cycles");
  AST_HALT_LEN: assert property (
    fetch_opcode ##1 (fetch_data == 8'h00) |=> !fetch_opcode [*5] ##1 halted)
    else $error("stop did not halt after 7 cycles");
  AST_ADD_IDX: assert property (
    fetch_opcode ##1 (fetch_data == 8'h03)
      |=> ##1 (op_issue && op_class == OP_ADD && op_mode == MODE_INDEXED))
    else $error("indexed add decoded wrongly");
  AST_CMP_DIR_LEN: assert property (
    fetch_opcode ##1 (fetch_data == 8'h17) |=> !fetch_opcode [*5] ##1 fetch_opcode)
    else $error("direct compare did not take 7 cycles");
  AST_PORTX: assert property (
    fetch_opcode ##1 (fetch_data == 8'h39)
      |=> ##1 op_issue && op_class == OP_PORT_WRITE_INDEXED && op_cycles == 4'h6)
    else $error("indexed port write decoded wrongly");
  AST_CALL_LEN: assert property (
    fetch_opcode ##1 (fetch_data[7:4] == 4'h9) |=> !fetch_opcode [*8] ##1 fetch_opcode)
    else $error("call did not take 10 cycles");
  AST_TABLE_LEN: assert property (
    fetch_opcode ##1 (fetch_data[7:4] == 4'hf)
      |=> !fetch_opcode [*8] ##1 !fetch_opcode [*4] ##1 fetch_opcode)
    else $error("table read did not take 14 cycles");
  AST_TARGET: assert property (
    (fetch_opcode ##1 fetch_data[7] ##1 1'b1) |=> op_issue && op_target[11:8] ==
      $past(fetch_data[3:0], 2) && op_target[7:0] == $past(fetch_data))
    else $error("jump target not formed from nibble and byte");
  AST_NO_OPR: assert property (
    fetch_opcode ##1 (fetch_data == 8'h3a) |-> !fetch_en ##1 !fetch_en)
    else $error("operand fetched for one-byte opcode");
  AST_HOLD: assert property (
    fetch_opcode && seen_q && !$past(halted) |-> gap_q == prev_cyc_q)
    else $error("instruction length differs from its cycle count");

  COV_HALT: cover property (fetch_opcode ##1 fetch_data == 8'h00 ##[6:7] halted);
  COV_CALL: cover property (op_issue && op_class == OP_CALL);
  COV_TABLE: cover property (op_issue && op_class == OP_TABLE_READ);
  COV_REDIR: cover property (redirect_valid && s_q.st == S_EXEC ##[1:14] fetch_opcode);

endmodule // mcuod_decode

// >>> tb/mcuod_prog_mem.sv
// program memory model feeding opcode and operand bytes to the decoder
`timescale 1ns/10ps

module mcuod_prog_mem (
  input  wire logic                         clock,
  input  wire logic                         fetch_en,
  input  wire logic [mcuod_pkg::ADDR_W-1:0] fetch_addr,
  output logic      [7:0]                   fetch_data
);
  import mcuod_pkg::*;

  logic [7:0] mem [0:4095];

  initial fetch_data = 8'h00;

  // one-cycle read; an unread cycle shows the stale byte inverted
  always @(posedge clock) begin
    if (fetch_en) begin
      fetch_data <= mem[fetch_addr];
    end else begin
      fetch_data <= ~fetch_data;
    end
  end
endmodule // mcuod_prog_mem

// >>> tb/mcu_opcode_decode_timing_test.sv
// self-checking bench for the opcode decoder and its cycle timer
`timescale 1ns/10ps

module mcu_opcode_decode_timing_test;
  import mcuod_pkg::*;

  typedef struct packed {
    logic [7:0]  opc;
    logic [7:0]  opr;
    logic        has;
    mcuod_op_e   cls;
    mcuod_mode_e mode;
    logic        mchk;
    logic [3:0]  cyc;
    logic [11:0] pc;
    logic [11:0] nxt;
    logic        zf;
    logic        cf;
    logic        rd;
  } mcuod_row_s;

  logic              clock;
  logic              resetn;
  logic              zero_flag;
  logic              carry_flag;
  logic              redirect_valid;
  logic [11:0]       redirect_pc;
  logic [7:0]        fetch_data;
  logic              fetch_en;
  logic              fetch_opcode;
  logic [11:0]       fetch_addr;
  logic              op_issue;
  mcuod_op_e         op_class;
  mcuod_mode_e       op_mode;
  logic [7:0]        op_operand;
  logic [11:0]       op_target;
  logic [3:0]        op_cycles;
  logic              op_illegal;
  logic              op_last;
  logic              halted;
  int                failures = 0;
  int                compares = 0;
  int                cycles = 0;
  int                ntab;
  logic [11:0]       pc = 12'h000;
  mcuod_row_s        rows[$];
  mcuod_op_e         alu[8] = '{OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_OR,
                                OP_AND, OP_XOR, OP_CMP};
  mcuod_op_e         acc[5] = '{OP_COMPLEMENT_ACCUMULATOR, OP_SHIFT_LEFT_ARITH,
                                OP_SHIFT_RIGHT_ARITH, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY};
  mcuod_op_e         jmp[8] = '{OP_JUMP, OP_CALL, OP_JUMP_IF_ZERO, OP_JUMP_IF_NOT_ZERO,
                                OP_JUMP_IF_CARRY, OP_JUMP_IF_NO_CARRY,
                                OP_JUMP_ACCUMULATOR_RELATIVE, OP_TABLE_READ};
  mcuod_op_e         mem3[3] = '{OP_OR_MEM, OP_AND_MEM, OP_XOR_MEM};
  mcuod_mode_e       m4[4] = '{MODE_ACC, MODE_XREG, MODE_DIRECT, MODE_INDEXED};
  mcuod_mode_e       fm[3] = '{MODE_IMM, MODE_DIRECT, MODE_INDEXED};
  logic [3:0]        jcy[8] = '{4'h5, 4'ha, 4'h5, 4'h5, 4'h5, 4'h5, 4'h7, 4'he};
  logic [3:0]        idc[4] = '{4'h4, 4'h4, 4'h7, 4'h8};

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  mcuod_decode dut (
    .clock(clock), .resetn(resetn), .fetch_data(fetch_data), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
    .fetch_en(fetch_en), .fetch_opcode(fetch_opcode), .fetch_addr(fetch_addr),
    .op_issue(op_issue), .op_class(op_class), .op_mode(op_mode), .op_operand(op_operand),
    .op_target(op_target), .op_cycles(op_cycles), .op_illegal(op_illegal),
    .op_last(op_last), .halted(halted)
  );

  mcuod_prog_mem prog (
    .clock(clock), .fetch_en(fetch_en), .fetch_addr(fetch_addr), .fetch_data(fetch_data)
  );

  // ********************
  // checking helpers
  // ********************
  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // table row laid out after the previous one; jumps aim at their own fall-through
  task automatic add(input logic [7:0] opc, input mcuod_op_e cls, input mcuod_mode_e mode,
                     input logic mchk, input logic [3:0] cyc, input logic has);
    mcuod_row_s r;
    logic [11:0] n2;
    n2 = pc + 12'h002;
    r = '0;
    r.opc = opc;
    r.opr = 8'h3c ^ opc;
    if (opc >= 8'h80) begin
      r.opc[3:0] = n2[11:8];
      r.opr = n2[7:0];
    end
    r.cls = cls;
    r.mode = mode;
    r.mchk = mchk;
    r.cyc = cyc;
    r.has = has;
    r.pc = pc;
    r.nxt = pc + 12'(1 + has);
    r.zf = pc[0];
    r.cf = pc[1];
    pc = r.nxt;
    rows.push_back(r);
  endtask

  task automatic fix(input logic [11:0] tgt, input logic [11:0] nxt, input logic zf,
                     input logic cf, input logic rd);
    mcuod_row_s r;
    r = rows.pop_back();
    if (r.opc >= 8'h80) begin
      r.opc[3:0] = tgt[11:8];
      r.opr = tgt[7:0];
    end
    r.nxt = nxt;
    r.zf = zf;
    r.cf = cf;
    r.rd = rd;
    pc = nxt;
    rows.push_back(r);
  endtask

  // runs one instruction from its opcode fetch cycle to the next one
  task automatic run(input mcuod_row_s r);
    int n;
    int last;
    n = 0;
    last = 0;
    while (fetch_opcode !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("fetch_addr", 32'(r.pc), 32'(fetch_addr));
    n = 0;
    do begin
      @(posedge clock);
      zero_flag <= r.zf;
      carry_flag <= r.cf;
      redirect_pc <= r.nxt;
      redirect_valid <= r.rd && n >= 1 && n < int'(r.cyc) - 1;
      @(negedge clock);
      n++;
      if (n == 1) chk("fetch_en", 32'(r.has), 32'(fetch_en));
      if (op_issue === 1'b1) begin
        chk("issue_cycle", 3, n);
        chk("op_class", 32'(r.cls), 32'(op_class));
        if (r.mchk) chk("op_mode", 32'(r.mode), 32'(op_mode));
        chk("op_cycles", 32'(r.cyc), 32'(op_cycles));
        chk("op_operand", r.has ? 32'(r.opr) : 0, 32'(op_operand));
        chk("op_illegal", 32'(r.cls == OP_ILLEGAL), 32'(op_illegal));
        if (r.opc >= 8'h80) chk("op_target", {r.opc[3:0], r.opr}, 32'(op_target));
      end
      if (op_last === 1'b1) last = n;
    end while (fetch_opcode !== 1'b1 && halted !== 1'b1 && n < 16);
    chk("cycles", 32'(r.cyc), n);
    chk("last_cycle", 32'(r.cyc) - 1, last);
    if (r.cls == OP_HALT) chk("halted", 1, 32'(halted));
    else chk("next_addr", 32'(r.nxt), 32'(fetch_addr));
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    resetn = 1'b0;
    zero_flag = 1'b0;
    carry_flag = 1'b0;
    redirect_valid = 1'b0;
    redirect_pc = 12'h000;
    for (int k = 0; k < 8; k++) begin
      for (int m = 0; m < 3; m++) begin
        add(8'(1 + 3 * k + m), alu[k], fm[m], 1'b1,
            4'((m == 0 ? 4 : m + 5) + (k == 7)), 1'b1);
      end
    end
    add(8'h19, OP_LOAD_ACC, MODE_IMM, 1'b1, 4'h4, 1'b1);
    add(8'h1a, OP_LOAD_ACC, MODE_DIRECT, 1'b1, 4'h5, 1'b1);
    add(8'h1b, OP_LOAD_ACC, MODE_INDEXED, 1'b1, 4'h6, 1'b1);
    add(8'h1c, OP_LOAD_X, MODE_IMM, 1'b1, 4'h4, 1'b1);
    add(8'h1d, OP_LOAD_X, MODE_DIRECT, 1'b1, 4'h5, 1'b1);
    add(8'h1e, OP_INTERRUPT_RETURN_WITH_OUTPUT, MODE_NONE, 1'b0, 4'hd, 1'b1);
    add(8'h1f, OP_PAGE_EXTEND_PREFIX, MODE_NONE, 1'b0, 4'h4, 1'b0);
    add(8'h20, OP_NOP, MODE_NONE, 1'b0, 4'h4, 1'b0);
    for (int j = 0; j < 8; j++) begin
      add(8'(8'h21 + j), j < 4 ? OP_INC : OP_DEC, m4[j % 4], 1'b1, idc[j % 4], j % 4 >= 2);
    end
    add(8'h29, OP_PORT_READ, MODE_NONE, 1'b0, 4'h5, 1'b1);
    add(8'h2a, OP_PORT_WRITE, MODE_NONE, 1'b0, 4'h5, 1'b1);
    add(8'h39, OP_PORT_WRITE_INDEXED, MODE_NONE, 1'b0, 4'h6, 1'b1);
    for (int j = 0; j < 4; j++) begin
      add(8'(8'h2b + j), j < 2 ? OP_POP : OP_PUSH, MODE_NONE, 1'b0, 4'(4 + j / 2), 1'b0);
    end
    add(8'h2f, OP_SWAP_X, MODE_NONE, 1'b0, 4'h5, 1'b0);
    add(8'h30, OP_SWAP_DSP, MODE_NONE, 1'b0, 4'h5, 1'b0);
    add(8'h31, OP_STORE, MODE_DIRECT, 1'b1, 4'h5, 1'b1);
    add(8'h32, OP_STORE, MODE_INDEXED, 1'b1, 4'h6, 1'b1);
    for (int j = 0; j < 6; j++) begin
      add(8'(8'h33 + j), mem3[j / 2], m4[2 + j % 2], 1'b1, 4'(7 + j % 2), 1'b1);
    end
    for (int j = 0; j < 5; j++) begin
      add(8'(8'h3a + j), acc[j], MODE_NONE, 1'b0, 4'h4, 1'b0);
    end
    add(8'h3f, OP_RETURN, MODE_NONE, 1'b0, 4'h8, 1'b0);
    add(8'h40, OP_ILLEGAL, MODE_NONE, 1'b0, 4'h4, 1'b0);
    for (int j = 0; j < 8; j++) begin
      add(8'(8'h80 + 16 * j), jmp[j], MODE_ADDR, 1'b1, jcy[j], 1'b1);
    end
    ntab = rows.size();
    // branches taken and not taken, redirect, last illegal code, stop
    add(8'ha0, OP_JUMP_IF_ZERO, MODE_ADDR, 1'b1, 4'h5, 1'b1);
    fix(12'h800, 12'h800, 1'b1, 1'b0, 1'b0);
    add(8'hb0, OP_JUMP_IF_NOT_ZERO, MODE_ADDR, 1'b1, 4'h5, 1'b1);
    fix(12'h900, 12'h802, 1'b1, 1'b0, 1'b0);
    add(8'hc0, OP_JUMP_IF_CARRY, MODE_ADDR, 1'b1, 4'h5, 1'b1);
    fix(12'h900, 12'h900, 1'b0, 1'b1, 1'b0);
    add(8'h3f, OP_RETURN, MODE_NONE, 1'b0, 4'h8, 1'b0);
    fix(12'h000, 12'ha00, 1'b0, 1'b0, 1'b1);
    add(8'h7f, OP_ILLEGAL, MODE_NONE, 1'b0, 4'h4, 1'b0);
    add(8'h00, OP_HALT, MODE_NONE, 1'b0, 4'h7, 1'b0);
    foreach (rows[i]) begin
      prog.mem[rows[i].pc] = rows[i].opc;
      prog.mem[rows[i].pc + 12'h001] = rows[i].opr;
    end
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    for (int i = 0; i < ntab; i++) run(rows[i]);
    $display("test table done");
    for (int i = ntab; i < rows.size(); i++) run(rows[i]);
    for (int i = 0; i < 8; i++) begin
      @(negedge clock);
      chk("fetch_en", 0, 32'(fetch_en));
    end
    $display("test branch and stop done");
    @(posedge clock);
    resetn <= 1'b0;
    @(negedge clock);
    chk("halted", 0, 32'(halted));
    chk("fetch_addr", 0, 32'(fetch_addr));
    chk("op_issue", 0, 32'(op_issue));
    @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    run(rows[0]);
    $display("test reset done");
    final_report();
  end
endmodule // mcu_opcode_decode_timing_test
